// [tep_pkg.sv]
// Package of constants shared by the receive error check and poison block.
package tep_pkg;
    localparam int TEP_HDR_W = 128;
    localparam int TEP_DATA_W = 64;
    // Header field positions, first header dword in bits 127:96.
    localparam int TEP_FMT_HI = 126;
    localparam int TEP_FMT_LO = 125;
    localparam int TEP_TYPE_HI = 124;
    localparam int TEP_TYPE_LO = 120;
    localparam int TEP_TC_HI = 118;
    localparam int TEP_TC_LO = 116;
    localparam int TEP_TD_BIT = 111;
    localparam int TEP_POISON_BIT = 110;
    localparam int TEP_LEN_HI = 105;
    localparam int TEP_LEN_LO = 96;
    localparam int TEP_LBE_HI = 71;
    localparam int TEP_LBE_LO = 68;
    localparam int TEP_FBE_HI = 67;
    localparam int TEP_FBE_LO = 64;
    localparam int TEP_ADDR32_HI = 31;
    localparam int TEP_ADDR32_LO = 2;
    localparam int TEP_ADDR64_HI = 31;
    localparam int TEP_ADDR64_LO = 2;
    // Format codes.
    localparam logic [1:0] TEP_FMT_3DW_ND = 2'h0;
    localparam logic [1:0] TEP_FMT_4DW_ND = 2'h1;
    localparam logic [1:0] TEP_FMT_3DW_D = 2'h2;
    localparam logic [1:0] TEP_FMT_4DW_D = 2'h3;
    // Type codes.
    localparam logic [4:0] TEP_TYPE_MEM = 5'h00;
    localparam logic [4:0] TEP_TYPE_MEMLK = 5'h01;
    localparam logic [4:0] TEP_TYPE_IO = 5'h02;
    localparam logic [4:0] TEP_TYPE_CFG0 = 5'h04;
    localparam logic [4:0] TEP_TYPE_CFG1 = 5'h05;
    localparam logic [4:0] TEP_TYPE_CPL = 5'h0A;
    localparam logic [4:0] TEP_TYPE_CPLLK = 5'h0B;
    localparam logic [1:0] TEP_TYPE_MSG_HI = 2'h2;
    localparam logic [2:0] TEP_TC_DEFAULT = 3'h0;
    localparam logic [3:0] TEP_BE_NONE = 4'h0;
    localparam logic [3:0] TEP_BE_ALL = 4'hF;
    localparam logic [9:0] TEP_LEN_ONE = 10'h001;
    // Dword offset within a 4 KB page is 10 bits, held in 11 bits with a zero top bit.
    localparam int TEP_PAGE_W = 11;
    localparam int TEP_DIGEST_DW = 1;
    // Flow control update timeout.
    localparam int TEP_FC_TIMEOUT_US = 200;
    localparam int TEP_CLK_MHZ = 200;
    localparam int TEP_FC_TIMEOUT_CYC = TEP_FC_TIMEOUT_US * TEP_CLK_MHZ;
    // Status register bit positions for the parity flags.
    localparam int TEP_STS_DPE_BIT = 15;
    localparam int TEP_STS_MDPE_BIT = 8;
    // Reset values.
    localparam logic TEP_FLAG_RST = 1'b0;
endpackage

// [tep_sticky.sv]
// One sticky status flag where a set in the same cycle beats a clear.
`timescale 1ns/1ps
module tep_sticky (
    input wire logic clk,
    input wire logic rstn,
    input wire logic setIn,
    input wire logic clrIn,
    output logic flag
);
    import tep_pkg::*;
    logic flag_nxt;

    // Next value: a set wins over a simultaneous clear.
    always_comb begin
        flag_nxt = flag;
        if (clrIn) begin
            flag_nxt = 1'b0;
        end
        if (setIn) begin
            flag_nxt = 1'b1;
        end
    end

    // Register the flag.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flag <= TEP_FLAG_RST;
        end else begin
            flag <= flag_nxt;
        end
    end
endmodule

// [tep_rx_check.sv]
// Receive packet error checks, poison handling and parity status bits.
// Summary of operation
// - Packet over advertised credits flags fatal receiver overflow and is dropped.
// - No credit update within 200 us raises fatal flow credit fault.
// - Payload longer than configured maximum makes the packet malformed.
// - Digest bit and digest presence disagreeing makes the packet malformed.
// - Byte enable rule violations make the packet malformed.
// - Format and length fields not matching actual length: malformed.
// - Undefined format and type combination makes the packet malformed.
// - Memory request crossing a 4 KB boundary is malformed.
// - Message on non-default traffic class is malformed.
// - Packet on an uninitialised virtual channel is malformed.
// - Poison bit equal to one marks a packet poisoned.
// - Poisoned packets are forwarded and error status updated together.
// - Poisoned configuration writes are not applied to configuration space.
// - Configuration space responses always carry poison bit zero.
// - Any accepted poisoned packet sets detected parity error, status bit 15.
// - Master data parity bit 8 set only with parity enable on.
// - Poisoned outbound application packets go to the link unchanged.
`timescale 1ns/1ps
module tep_rx_check #(
    parameter int FC_TIMEOUT_CYC = tep_pkg::TEP_FC_TIMEOUT_CYC,
    parameter int VC_NUM = 1
) (
    input wire logic clk_sys,
    input wire logic resetn,
    // Received packet from the link side: header, dword count and flags, one cycle.
    input wire logic rxValid,
    input wire logic [tep_pkg::TEP_HDR_W-1:0] rxHdr,
    input wire logic [10:0] rxDataDw,
    input wire logic rxDigest,
    input wire logic [2:0] rxVc,
    input wire logic rxCreditOk,
    input wire logic fcUpdate,
    input wire logic [VC_NUM-1:0] vcInit,
    input wire logic [10:0] maxPayloadDw,
    // Parity enable bit of the command register.
    input wire logic parityEnable,
    input wire logic statusClear,
    // Outbound application packet and configuration response paths.
    input wire logic txValid,
    input wire logic [tep_pkg::TEP_HDR_W-1:0] txHdr,
    input wire logic cfgRspValid,
    input wire logic [tep_pkg::TEP_HDR_W-1:0] cfgRspHdr,
    // Forwarded received descriptor to the application.
    output logic appValid,
    output logic [tep_pkg::TEP_HDR_W-1:0] appHdr,
    output logic appPoison,
    output logic cfgWrValid,
    output logic [tep_pkg::TEP_HDR_W-1:0] cfgWrHdr,
    output logic linkValid,
    output logic [tep_pkg::TEP_HDR_W-1:0] linkHdr,
    output logic rxOverflowErr,
    output logic flow_credit_protocol_fault,
    output logic malformedErr,
    output logic poisonRcvd,
    output logic statusDetParity,
    output logic statusMasterParity
);
    import tep_pkg::*;

    logic rstSync1_r;
    logic rstSync2_r;
    logic rstn;

    // Reset release through two flip-flops.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rstSync1_r <= 1'b0;
            rstSync2_r <= 1'b0;
        end else begin
            rstSync1_r <= 1'b1;
            rstSync2_r <= rstSync1_r;
        end
    end
    assign rstn = rstSync2_r;

    // Header field extraction.
    logic [1:0] fmt;
    logic [4:0] typ;
    logic [2:0] tc;
    logic tdBit;
    logic poisonBit;
    logic [9:0] lenDw;
    logic [3:0] fbe;
    logic [3:0] lbe;
    logic hasData;
    logic is4dw;
    logic isMem;
    logic isIo;
    logic isCfg;
    logic isCpl;
    logic isMsg;
    logic isCfgWr;
    logic [11:0] lenEff;
    logic [TEP_PAGE_W-1:0] pageOff;
    assign fmt = rxHdr[TEP_FMT_HI:TEP_FMT_LO];
    assign typ = rxHdr[TEP_TYPE_HI:TEP_TYPE_LO];
    assign tc = rxHdr[TEP_TC_HI:TEP_TC_LO];
    assign tdBit = rxHdr[TEP_TD_BIT];
    assign poisonBit = rxHdr[TEP_POISON_BIT];
    assign lenDw = rxHdr[TEP_LEN_HI:TEP_LEN_LO];
    assign fbe = rxHdr[TEP_FBE_HI:TEP_FBE_LO];
    assign lbe = rxHdr[TEP_LBE_HI:TEP_LBE_LO];
    assign hasData = fmt[1];
    assign is4dw = fmt[0];
    assign isMem = (typ == TEP_TYPE_MEM) || (typ == TEP_TYPE_MEMLK);
    assign isIo = (typ == TEP_TYPE_IO);
    assign isCfg = (typ == TEP_TYPE_CFG0) || (typ == TEP_TYPE_CFG1);
    assign isCpl = (typ == TEP_TYPE_CPL) || (typ == TEP_TYPE_CPLLK);
    assign isMsg = (typ[4:3] == TEP_TYPE_MSG_HI);
    assign isCfgWr = isCfg && hasData;
    // Length zero encodes 1024 dwords.
    assign lenEff = (lenDw == 10'h000) ? 12'h400 : {2'h0, lenDw};
    // Dword offset within the 4 KB page from the low address.
    assign pageOff = is4dw ? {1'b0, rxHdr[TEP_ADDR64_LO+9:TEP_ADDR64_LO]}
                           : {1'b0, rxHdr[TEP_ADDR32_LO+9:TEP_ADDR32_LO]};

    // Individual malformed checks.
    logic badPayload;
    logic badDigest;
    logic badBe;
    logic badLen;
    logic badFmtType;
    logic badBoundary;
    logic badMsgTc;
    logic badVc;
    logic vcReady;
    logic malformed;
    logic [12:0] expDw;
    logic [12:0] endOff;

    always_comb begin
        badPayload = hasData && (lenEff > {1'b0, maxPayloadDw});
        badDigest = (tdBit != rxDigest);
        // Single dword requests need zero last enables; longer ones need both set.
        badBe = 1'b0;
        if (isMem || isIo || isCfg) begin
            if (lenEff == {2'h0, TEP_LEN_ONE}) begin
                badBe = (lbe != TEP_BE_NONE);
            end else begin
                badBe = (lbe == TEP_BE_NONE) || (fbe == TEP_BE_NONE);
            end
            if ((isIo || isCfg) && (lenEff != {2'h0, TEP_LEN_ONE})) begin
                badBe = 1'b1;
            end
        end
        expDw = hasData ? {1'b0, lenEff} : 13'h0000;
        badLen = ({2'h0, rxDataDw} != expDw);
        unique case (typ)
            TEP_TYPE_MEM, TEP_TYPE_MEMLK: badFmtType = 1'b0;
            TEP_TYPE_IO, TEP_TYPE_CFG0, TEP_TYPE_CFG1: badFmtType = is4dw;
            TEP_TYPE_CPL, TEP_TYPE_CPLLK: badFmtType = is4dw;
            default: badFmtType = !(isMsg && is4dw);
        endcase
        endOff = {2'h0, pageOff} + {1'b0, lenEff};
        badBoundary = isMem && (endOff > 13'h0400);
        badMsgTc = isMsg && (tc != TEP_TC_DEFAULT);
        vcReady = 1'b0;
        for (int i = 0; i < VC_NUM; i++) begin
            if (rxVc == 3'(i)) begin
                vcReady = vcInit[i];
            end
        end
        badVc = !vcReady;
        malformed = badPayload || badDigest || badBe || badLen || badFmtType
                    || badBoundary || badMsgTc || badVc;
    end

    // Flow control update watchdog; it restarts on every update and after a fault.
    // A dead link therefore keeps reporting the fault once per expired interval.
    localparam int FC_CNT_W = $clog2(FC_TIMEOUT_CYC + 1);
    localparam logic [FC_CNT_W-1:0] FC_LAST = FC_CNT_W'(FC_TIMEOUT_CYC - 1);
    localparam logic [FC_CNT_W-1:0] FC_STEP = FC_CNT_W'(1);
    logic [FC_CNT_W-1:0] fcCnt_r;
    logic [FC_CNT_W-1:0] fcCnt_nxt;
    logic fcFault_nxt;
    always_comb begin
        fcFault_nxt = 1'b0;
        if (fcUpdate) begin
            fcCnt_nxt = '0;
        end else if (fcCnt_r == FC_LAST) begin
            fcCnt_nxt = '0;
            fcFault_nxt = 1'b1;
        end else begin
            fcCnt_nxt = fcCnt_r + FC_STEP;
        end
    end

    // Forward and error pulse next values.
    logic overflow;
    logic dropIt;
    logic accepted;
    logic appValid_nxt;
    logic appPoison_nxt;
    logic cfgWrValid_nxt;
    logic linkValid_nxt;
    logic [TEP_HDR_W-1:0] linkHdr_nxt;
    logic ovfErr_nxt;
    logic malErr_nxt;
    logic poisonRcvd_nxt;
    logic txPoisonWr;
    logic rxPoisonCpl;
    logic mdpeSet;
    always_comb begin
        overflow = rxValid && !rxCreditOk;
        dropIt = overflow || malformed;
        // A packet survives when it fits the credits and passes every malformed check.
        accepted = rxValid && !dropIt;
        appValid_nxt = accepted && !isCfg;
        // Only a packet that really reaches the application carries the poison flag out.
        appPoison_nxt = appValid_nxt && poisonBit;
        cfgWrValid_nxt = accepted && isCfgWr && !poisonBit;
        // A response offered together with an outbound packet is lost, so callers keep them apart.
        linkValid_nxt = txValid || cfgRspValid;
        if (txValid) begin
            linkHdr_nxt = txHdr;
        end else begin
            linkHdr_nxt = cfgRspHdr;
            linkHdr_nxt[TEP_POISON_BIT] = 1'b0;
        end
        // Each error pulse lasts one cycle, so every offending packet is reported once.
        ovfErr_nxt = overflow;
        // Overflow already reports the packet, so the malformed pulse stays quiet then.
        malErr_nxt = rxValid && !overflow && malformed;
        poisonRcvd_nxt = accepted && poisonBit;
        // Master parity: a poisoned memory write going out or a poisoned completion coming in.
        txPoisonWr = txValid && txHdr[TEP_POISON_BIT] && txHdr[TEP_FMT_HI]
                     && (txHdr[TEP_TYPE_HI:TEP_TYPE_LO] == TEP_TYPE_MEM);
        rxPoisonCpl = accepted && isCpl && poisonBit;
        mdpeSet = parityEnable && (txPoisonWr || rxPoisonCpl);
    end

    // Register the flow control watchdog and its fault pulse.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            fcCnt_r <= '0;
            flow_credit_protocol_fault <= 1'b0;
        end else begin
            fcCnt_r <= fcCnt_nxt;
            flow_credit_protocol_fault <= fcFault_nxt;
        end
    end

    // Register the receive forwarding outputs.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            appValid <= 1'b0;
            appHdr <= '0;
            appPoison <= 1'b0;
            cfgWrValid <= 1'b0;
            cfgWrHdr <= '0;
        end else begin
            appValid <= appValid_nxt;
            appHdr <= rxHdr;
            appPoison <= appPoison_nxt;
            cfgWrValid <= cfgWrValid_nxt;
            cfgWrHdr <= rxHdr;
        end
    end

    // Register the outbound link path.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            linkValid <= 1'b0;
            linkHdr <= '0;
        end else begin
            linkValid <= linkValid_nxt;
            linkHdr <= linkHdr_nxt;
        end
    end

    // Register the one-per-packet error pulses.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rxOverflowErr <= 1'b0;
            malformedErr <= 1'b0;
            poisonRcvd <= 1'b0;
        end else begin
            rxOverflowErr <= ovfErr_nxt;
            malformedErr <= malErr_nxt;
            poisonRcvd <= poisonRcvd_nxt;
        end
    end

    // Sticky parity status bits; a set in the same cycle beats the software clear.
    tep_sticky uDetParity (
        .clk(clk_sys),
        .rstn(rstn),
        .setIn(poisonRcvd_nxt),
        .clrIn(statusClear),
        .flag(statusDetParity)
    );

    tep_sticky uMasterParity (
        .clk(clk_sys),
        .rstn(rstn),
        .setIn(mdpeSet),
        .clrIn(statusClear),
        .flag(statusMasterParity)
    );
endmodule

// [tep_rx_check_sva.sv]
// Concurrent checks on the ports of the receive error check and poison block.
`timescale 1ns/1ps
module tep_rx_check_sva #(
    parameter int FC_TIMEOUT_CYC = 40000
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic rxValid,
    input wire logic rxCreditOk,
    input wire logic fcUpdate,
    input wire logic txValid,
    input wire logic [tep_pkg::TEP_HDR_W-1:0] txHdr,
    input wire logic cfgRspValid,
    input wire logic parityEnable,
    input wire logic statusClear,
    input wire logic appValid,
    input wire logic [tep_pkg::TEP_HDR_W-1:0] appHdr,
    input wire logic appPoison,
    input wire logic cfgWrValid,
    input wire logic [tep_pkg::TEP_HDR_W-1:0] cfgWrHdr,
    input wire logic linkValid,
    input wire logic [tep_pkg::TEP_HDR_W-1:0] linkHdr,
    input wire logic rxOverflowErr,
    input wire logic flow_credit_protocol_fault,
    input wire logic malformedErr,
    input wire logic poisonRcvd,
    input wire logic statusDetParity,
    input wire logic statusMasterParity
);
    import tep_pkg::*;
    // All checks share the core clock and its reset.
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    // A credit update followed by a quiet stretch of the fault line.
    sequence s_upd;
        fcUpdate;
    endsequence
    sequence s_calm;
        !flow_credit_protocol_fault [*8];
    endsequence
    a_fc_quiet: assert property (s_upd |=> s_calm) else $error("fault right after update");
    a_ovf_drop: assert property (rxValid && !rxCreditOk |=> rxOverflowErr && !appValid
        && !malformedErr && !cfgWrValid) else $error("overflow packet not dropped");
    a_mal_drop: assert property (malformedErr |-> !appValid && !cfgWrValid)
        else $error("malformed packet forwarded");
    a_app_flag: assert property (appValid |-> appPoison == appHdr[TEP_POISON_BIT])
        else $error("poison flag wrong on forwarded packet");
    a_det_par: assert property (poisonRcvd |-> statusDetParity)
        else $error("bit 15 not set");
    a_pois_gate: assert property (appPoison |-> appValid)
        else $error("poison flag without a packet");
    a_wr_clean: assert property (cfgWrValid |-> !cfgWrHdr[TEP_POISON_BIT])
        else $error("poisoned config write applied");
    a_tx_pass: assert property (txValid |=> linkValid && linkHdr == $past(txHdr))
        else $error("outbound packet altered");
    a_cfg_clean: assert property (cfgRspValid && !txValid |=> linkValid
        && !linkHdr[TEP_POISON_BIT]) else $error("config response poisoned");
    a_mdp_gate: assert property ($rose(statusMasterParity) |-> $past(parityEnable))
        else $error("bit 8 set without parity enable");
    a_sts_hold: assert property (statusDetParity && !statusClear |=> statusDetParity)
        else $error("bit 15 lost without clear");
endmodule
bind tep_rx_check tep_rx_check_sva #(.FC_TIMEOUT_CYC(FC_TIMEOUT_CYC)) i_tep_rx_check_sva (.*);

// [tep_link_model.sv]
// Far side model: credit updates from the link and the application sink.
`timescale 1ns/1ps
module tep_link_model (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic fcEn,
    input wire logic appValid,
    input wire logic appPoison,
    output logic fcUpdate,
    output int nPois
);
    logic [3:0] tick_r;
    // Sends a one cycle credit update every sixteen cycles and counts poisoned deliveries.
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tick_r <= 4'h0;
            fcUpdate <= 1'b0;
            nPois <= 0;
        end else begin
            tick_r <= tick_r + 4'h1;
            fcUpdate <= fcEn && (tick_r == 4'hF);
            if (appValid && appPoison) nPois <= nPois + 1;
        end
    end
endmodule

// [tep_rx_check_tb.sv]
// Self-checking bench for the receive error check and poison block.
`timescale 1ns/1ps
module tep_rx_check_tb;
    import tep_pkg::*;
    localparam int FCC = 50;
    localparam logic [TEP_HDR_W-1:0] EPM = 128'h1 << TEP_POISON_BIT;
    localparam logic [1:0] F3D = TEP_FMT_3DW_D;
    logic clk_sys = 1'b0, resetn = 1'b0, rxValid = 1'b0, rxDigest = 1'b0, rxCreditOk = 1'b1;
    logic parityEnable = 1'b0, statusClear = 1'b0, txValid = 1'b0, cfgRspValid = 1'b0;
    logic [TEP_HDR_W-1:0] rxHdr = '0, txHdr = '0, cfgRspHdr = '0, appHdr, cfgWrHdr, linkHdr, g, c;
    logic [10:0] rxDataDw = 11'h000, maxPayloadDw = 11'h008;
    logic [2:0] rxVc = 3'h0;
    logic [1:0] vcInit = 2'h1;
    logic fcUpdate, appValid, appPoison, cfgWrValid, linkValid, rxOverflowErr, malformedErr;
    logic flow_credit_protocol_fault, poisonRcvd, statusDetParity, statusMasterParity;
    logic fcEn = 1'b1, expDet = 1'b0, expMdp = 1'b0;
    int n_errors = 0, checks = 0, cyc = 0, lastUpd = 0, nPois, expPois = 0;
    tep_rx_check #(.FC_TIMEOUT_CYC(FCC), .VC_NUM(2)) i_tep_rx_check (.*);
    tep_link_model i_tep_link_model (.*);
    initial forever #2.5 clk_sys = ~clk_sys;
    // Counts edges and notes the edge at which the last credit update was taken.
    always @(posedge clk_sys) begin
        cyc++;
        if (fcUpdate) lastUpd = cyc;
    end
    function automatic logic [TEP_HDR_W-1:0] hd(input logic [1:0] f, input logic [4:0] t,
        input logic [2:0] tc, input logic ep, input logic [9:0] ln, input logic [7:0] be,
        input logic [31:0] a);
        hd = {1'b0, f, t, 1'b0, tc, 4'h0, 1'b0, ep, 4'h0, ln, 24'h0, be, 32'h0, a};
    endfunction
    task automatic chk(input logic gv, input logic ev);
        checks++;
        if (gv !== ev) begin
            n_errors++;
            $display("unexpected at %0t: flag %b not %b", $time, gv, ev);
        end
    endtask
    task automatic chkH(input logic [TEP_HDR_W-1:0] gv, input logic [TEP_HDR_W-1:0] ev);
        checks++;
        if (gv !== ev) begin
            n_errors++;
            $display("unexpected at %0t: header %h", $time, gv);
        end
    endtask
    task automatic print_verdict;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Kind: 0 forwarded, 1 overflow, 2 malformed, 3 config write, 4 dropped config write.
    task automatic sendRx(input logic [TEP_HDR_W-1:0] h, input logic [10:0] dw, input int k);
        logic p;
        rxHdr = h;
        rxDataDw = dw;
        rxValid = 1'b1;
        @(posedge clk_sys);
        #1 rxValid = 1'b0;
        p = h[TEP_POISON_BIT] && k != 1 && k != 2;
        expDet = expDet | p;
        if (p && h[TEP_TYPE_HI:TEP_TYPE_LO] == TEP_TYPE_CPL && parityEnable) expMdp = 1'b1;
        if (k == 0 && h[TEP_POISON_BIT]) expPois++;
        chk(appValid, k == 0);
        chk(rxOverflowErr, k == 1);
        chk(malformedErr, k == 2);
        chk(cfgWrValid, k == 3);
        chk(poisonRcvd, p);
        chk(statusDetParity, expDet);
        chk(statusMasterParity, expMdp);
        if (k == 0) chkH(appHdr, h);
        if (k == 3) chkH(cfgWrHdr, h);
        chk(appPoison, k == 0 && h[TEP_POISON_BIT]);
        // One idle edge keeps the next packet from raising valid in this same step.
        @(posedge clk_sys);
        #1;
    endtask
    task automatic sendTx(input logic [TEP_HDR_W-1:0] h, input logic cr);
        txHdr = h;
        cfgRspHdr = h;
        txValid = !cr;
        cfgRspValid = cr;
        @(posedge clk_sys);
        #1 txValid = 1'b0;
        cfgRspValid = 1'b0;
        if (!cr && h[TEP_POISON_BIT] && parityEnable) expMdp = 1'b1;
        h[TEP_POISON_BIT] = h[TEP_POISON_BIT] & !cr;
        chk(linkValid, 1'b1);
        chkH(linkHdr, h);
        chk(statusMasterParity, expMdp);
        @(posedge clk_sys);
        #1;
    endtask
    // Main sequence of scenarios.
    initial begin
        logic [9:0] ln;
        int n;
        void'($urandom(43440));
        repeat (16) @(posedge clk_sys);
        #1 resetn = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        for (int i = 0; i < 16; i++) begin
            ln = 10'($urandom_range(4, 1));
            g = hd(TEP_FMT_3DW_D, TEP_TYPE_MEM, 3'h0, 1'($urandom), ln,
                (ln == 10'h001) ? 8'h0F : 8'hFF, {20'h0, 10'($urandom_range(1000, 0)), 2'h0});
            sendRx(g, {1'b0, ln}, 0);
        end
        g = hd(TEP_FMT_3DW_D, TEP_TYPE_MEM, 3'h0, 1'b0, 10'h004, 8'hFF, 32'h100);
        c = hd(TEP_FMT_3DW_D, TEP_TYPE_CFG0, 3'h0, 1'b0, 10'h001, 8'h0F, 32'h0);
        rxCreditOk = 1'b0;
        sendRx(g, 11'h004, 1);
        rxCreditOk = 1'b1;
        sendRx(hd(F3D, TEP_TYPE_MEM, 3'h0, 1'b0, 10'h010, 8'hFF, 32'h0), 11'h010, 2);
        sendRx(g ^ (128'h1 << TEP_TD_BIT), 11'h004, 2);
        rxDigest = 1'b1;
        sendRx(g, 11'h004, 2);
        rxDigest = 1'b0;
        sendRx(hd(F3D, TEP_TYPE_MEM, 3'h0, 1'b0, 10'h001, 8'hFF, 32'h0), 11'h001, 2);
        sendRx(hd(F3D, TEP_TYPE_IO, 3'h0, 1'b0, 10'h002, 8'hFF, 32'h0), 11'h002, 2);
        sendRx(g, 11'h005, 2);
        sendRx(g | (128'h1F << TEP_TYPE_LO), 11'h004, 2);
        sendRx({g[127:32], 32'h0000_0FF8}, 11'h004, 2);
        sendRx(hd(TEP_FMT_4DW_ND, 5'h10, 3'h1, 1'b0, 10'h000, 8'h00, 32'h0), 11'h000, 2);
        rxVc = 3'h1;
        sendRx(g, 11'h004, 2);
        rxVc = 3'h0;
        sendRx(c, 11'h001, 3);
        sendRx(c | EPM, 11'h001, 4);
        g = hd(TEP_FMT_3DW_D, TEP_TYPE_CPL, 3'h0, 1'b1, 10'h001, 8'h0F, 32'h0);
        sendRx(g, 11'h001, 0);
        parityEnable = 1'b1;
        sendRx(g, 11'h001, 0);
        // A clear in the cycle of a new poisoned completion loses to the set.
        statusClear = 1'b1;
        sendRx(g, 11'h001, 0);
        statusClear = 1'b0;
        chk(statusDetParity, 1'b0);
        chk(statusMasterParity, 1'b0);
        expDet = 1'b0;
        expMdp = 1'b0;
        sendTx(hd(TEP_FMT_3DW_D, TEP_TYPE_MEM, 3'h0, 1'b1, 10'h004, 8'hFF, 32'h40), 1'b0);
        sendTx(c | EPM, 1'b1);
        fcEn = 1'b0;
        for (n = 0; n < 200 && flow_credit_protocol_fault !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        if (n == 200) begin
            n_errors++;
            $display("unexpected at %0t: no flow credit fault", $time);
        end
        chk(cyc - lastUpd == FCC, 1'b1);
        chk(nPois == expPois, 1'b1);
        print_verdict();
    end
endmodule
